/* File: include/freq_det_if.sv */
/*
 * Carrier between the clock controller and its frequency window detector.
 * Assumes both ends run on the same system clock.
 */
interface freq_det_if;
  logic        ext_edge;   // One-cycle pulse per external rising edge
  logic [15:0] expected;   // Expected edges per measuring window
  logic [6:0]  window_pct; // Allowed deviation in percent
  logic        done;       // Pulse at the end of each window
  logic        in_window;  // Valid with done

  modport det (input ext_edge, expected, window_pct, output done, in_window);
  modport ctl (output ext_edge, expected, window_pct, input done, in_window);
endinterface

/* File: include/pwm_clk_pkg.sv */
/*
 * Constants, lookup tables and types for the PWM clock and switching-frequency block.
 * Assumes a single 20 MHz system clock; nothing here holds state.
 */
package pwm_clk_pkg;

  // ----------------------------------------------------------------
  // Sizes and system clock
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 4;    // PWM channels
  localparam int NUM_GPIO     = 6;    // General purpose pins
  localparam int CLK_PERIOD_NS = 50;  // 20 MHz system clock

  // ----------------------------------------------------------------
  // Frequency select register layout and reset value
  // ----------------------------------------------------------------
  localparam int FSEL_OSC_LSB = 4;    // Oscillator code [6:4]
  localparam int FSEL_OSC_MSB = 6;
  localparam int FSEL_DIV_LSB = 0;    // Divider code [2:0]
  localparam int FSEL_DIV_MSB = 2;
  localparam logic [7:0] FSEL_RESET = 8'h01;  // 48 MHz, divide by 32

  // ----------------------------------------------------------------
  // Sync mode configuration bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_EXT_EN_BIT = 0;  // Use external clock
  localparam int SYNC_MASTER_BIT = 1;  // Master role
  localparam int SYNC_SLAVE_BIT  = 2;  // Slave role
  localparam int SYNC_AUTO_BIT   = 3;  // Automatic switch-back

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PERIOD_MULT = 16;     // Oscillator periods per divider step
  localparam int MIN_ON_NS   = 40;     // Least high-side on time
  localparam int MIN_ON_CYC_RAW = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_CYC  = (MIN_ON_CYC_RAW < 1) ? 1 : MIN_ON_CYC_RAW;
  localparam int PCT_FULL    = 100;    // Duty and window unit

  // ----------------------------------------------------------------
  // Lookup tables, indexed by code
  // ----------------------------------------------------------------
  localparam logic [15:0] OSC_KHZ [8] = '{16'hBB80, 16'hAF00, 16'hA280, 16'h9600,
                                          16'h8980, 16'h7D00, 16'h7080, 16'h6400};
  localparam logic [6:0] DUTY_REC_PCT [8] = '{7'h00, 7'h4E, 7'h56, 7'h54,
                                              7'h59, 7'h58, 7'h58, 7'h56};

  // ----------------------------------------------------------------
  // Clock source states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_BOOT, ST_DETECT, ST_EXT, ST_INT} clk_state_t;

  // Combination that has no defined switching frequency
  function automatic logic freq_combo_invalid(input logic [2:0] osc,
                                              input logic [2:0] div);
    freq_combo_invalid = (div == 3'h0) ||
                         (div == 3'h5 && osc == 3'h7) ||
                         (div == 3'h6 && osc >= 3'h5) ||
                         (div == 3'h7 && osc >= 3'h4);
  endfunction

endpackage

/* File: rtl/freq_window_det.sv */
/*
 * Frequency window detector: counts external edges over a fixed run of system clocks
 * and reports whether the count lies within a percentage of the expected count.
 * Assumes the edge pulse is already synchronised to i_mclk.
 */
module freq_window_det #(
  parameter int REF_WINDOW = 1024   // System clocks per measurement
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  freq_det_if.det   det
);

  if (REF_WINDOW < 2 || REF_WINDOW > 65535) begin : g_bad_window
    $error("REF_WINDOW out of range");
  end

  // ----------------------------------------------------------------
  // Window timer and edge counter
  // ----------------------------------------------------------------
  logic [15:0] ref_cnt_r;    // Cycles into current window
  logic [15:0] edge_cnt_r;   // Edges seen in current window
  logic        last_cyc;     // Final cycle of the window
  logic [31:0] diff;         // Distance from expected count
  logic [31:0] lhs;
  logic [31:0] rhs;

  assign last_cyc = (ref_cnt_r == 16'(REF_WINDOW - 1));

  // Free-running window timer
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt_r <= 16'h0000;
    end else if (last_cyc) begin
      ref_cnt_r <= 16'h0000;
    end else begin
      ref_cnt_r <= ref_cnt_r + 16'h0001;
    end
  end

  // Edge counter, restarted each window; saturates
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      edge_cnt_r <= 16'h0000;
    end else if (last_cyc) begin
      edge_cnt_r <= 16'h0000;
    end else if (det.ext_edge && edge_cnt_r != 16'hFFFF) begin
      edge_cnt_r <= edge_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Window comparison
  // ----------------------------------------------------------------
  always_comb begin
    diff = (edge_cnt_r >= det.expected) ? 32'(edge_cnt_r - det.expected)
                                        : 32'(det.expected - edge_cnt_r);
    lhs  = diff * 32'(pwm_clk_pkg::PCT_FULL);
    rhs  = 32'(det.expected) * 32'(det.window_pct);
  end

  // Verdict, registered with its strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      det.done      <= 1'b0;
      det.in_window <= 1'b0;
    end else begin
      det.done      <= last_cyc;
      if (last_cyc) begin
        det.in_window <= (det.expected != 16'h0000) && (lhs <= rhs);
      end
    end
  end

endmodule

/* File: rtl/pwm_clock_freq_sync.sv */
/*
 * Clock source and switching-frequency control for a four channel PWM controller:
 * frequency select decode, duty ceiling, external clock detection and switchover,
 * master clock and sync forwarding on general purpose pins.
 * Assumes register values come from same-clock configuration logic and GPIO
 * inputs are asynchronous pins.
 */
// Contract
// - Select bits [6:4] oscillator, [2:0] divider
// - Oscillator codes map 48 down to 25.6 MHz
// - Switching period is sixteen times (code+1)
// - High-side pulse never shorter than 40 ns
// - Duty clamped at channel ceiling, always; the one-tick minimum pulse can exceed it
// - Higher ceiling accepted; overcurrent flags then invalid
// - Sync mode picks source and role
// - Always start on internal clock
// - Switch to external only inside window; slave mode switches without a window check
// - No valid external clock: stay internal, except in slave mode
// - Auto switch-back on external clock failure
// - Master forwards clock and sync after loading
// - Slave takes master clock after loading
// - GPIO pins serve as clock inputs
module pwm_clock_freq_sync #(
  parameter int REF_WINDOW = 1024   // Detector window in system clocks
) (
  input  wire logic                                     i_mclk,
  input  wire logic                                     i_rst,
  input  wire logic [7:0]                               i_switching_frequency_select,
  input  wire logic [3:0]                               i_sync_mode,
  input  wire logic [6:0]                               i_window_pct,
  input  wire logic [15:0]                              i_ext_expected,
  input  wire logic                                     i_cfg_loaded,
  input  wire logic [2:0]                               i_clk_in_sel,
  input  wire logic [2:0]                               i_clk_out_sel,
  input  wire logic [2:0]                               i_sync_out_sel,
  input  wire logic [pwm_clk_pkg::NUM_CH-1:0][6:0]      i_duty_request,
  input  wire logic [pwm_clk_pkg::NUM_CH-1:0][6:0]      i_channel_duty_ceiling,
  input  wire logic [pwm_clk_pkg::NUM_GPIO-1:0]         i_gpio_in,
  output logic      [pwm_clk_pkg::NUM_GPIO-1:0]         o_gpio_out,
  output logic      [pwm_clk_pkg::NUM_GPIO-1:0]         o_gpio_oe_n,
  output logic      [pwm_clk_pkg::NUM_CH-1:0]           o_pwm,
  output logic      [pwm_clk_pkg::NUM_CH-1:0]           o_ocp_flags_invalid,
  output logic      [15:0]                              o_osc_khz,
  output logic      [7:0]                               o_period_ticks,
  output logic      [6:0]                               o_duty_rec_pct,
  output logic                                          o_freq_invalid,
  output logic                                          o_clk_src_ext,
  output logic      [1:0]                               o_clk_state
);

  if (REF_WINDOW < 2 || REF_WINDOW > 4096) begin : g_bad_window
    $error("REF_WINDOW out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and external edge
  // ----------------------------------------------------------------
  logic [pwm_clk_pkg::NUM_GPIO-1:0] gpio_s1_r;   // First stage, read by second only
  logic [pwm_clk_pkg::NUM_GPIO-1:0] gpio_s2_r;   // Safe pin levels
  logic                             ext_prev_r;  // Previous external level
  logic                             ext_lvl;     // Selected clock input level
  logic                             ext_edge;    // Rising edge pulse

  // Two-stage synchroniser on all pins
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gpio_s1_r <= '0;
      gpio_s2_r <= '0;
    end else begin
      gpio_s1_r <= i_gpio_in;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  // Any pin may be chosen as clock input
  assign ext_lvl  = (i_clk_in_sel < 3'(pwm_clk_pkg::NUM_GPIO)) ?
                    gpio_s2_r[i_clk_in_sel] : 1'b0;
  assign ext_edge = ext_lvl & ~ext_prev_r;

  // Edge detector history
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Frequency select decode
  // ----------------------------------------------------------------
  logic [2:0] osc_code;
  logic [2:0] div_code;
  logic       combo_bad;
  logic [6:0] duty_rec;

  assign osc_code  = i_switching_frequency_select[pwm_clk_pkg::FSEL_OSC_MSB:
                                                  pwm_clk_pkg::FSEL_OSC_LSB];
  assign div_code  = i_switching_frequency_select[pwm_clk_pkg::FSEL_DIV_MSB:
                                                  pwm_clk_pkg::FSEL_DIV_LSB];
  assign combo_bad = pwm_clk_pkg::freq_combo_invalid(osc_code, div_code);
  assign duty_rec  = pwm_clk_pkg::DUTY_REC_PCT[div_code];

  // Registered status of the decoded setting
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_osc_khz      <= 16'h0000;
      o_duty_rec_pct <= 7'h00;
      o_freq_invalid <= 1'b0;
    end else begin
      o_osc_khz      <= pwm_clk_pkg::OSC_KHZ[osc_code];
      o_duty_rec_pct <= pwm_clk_pkg::DUTY_REC_PCT[div_code];
      o_freq_invalid <= combo_bad;
    end
  end

  // ----------------------------------------------------------------
  // Clock source state machine
  // ----------------------------------------------------------------
  pwm_clk_pkg::clk_state_t state_r;
  logic ext_en;
  logic is_master;
  logic is_slave;
  logic auto_back;

  freq_det_if det_if ();

  assign ext_en    = i_sync_mode[pwm_clk_pkg::SYNC_EXT_EN_BIT];
  assign is_master = i_sync_mode[pwm_clk_pkg::SYNC_MASTER_BIT];
  assign is_slave  = i_sync_mode[pwm_clk_pkg::SYNC_SLAVE_BIT];
  assign auto_back = i_sync_mode[pwm_clk_pkg::SYNC_AUTO_BIT];

  assign det_if.ext_edge   = ext_edge;
  assign det_if.expected   = i_ext_expected;
  assign det_if.window_pct = i_window_pct;

  freq_window_det #(
    .REF_WINDOW (REF_WINDOW)
  ) u_det (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .det    (det_if)
  );

  // Source selection; reset lands on internal clock
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= pwm_clk_pkg::ST_BOOT;
    end else begin
      unique case (state_r)
        pwm_clk_pkg::ST_BOOT: begin
          // Internal clock until configuration is loaded
          if (i_cfg_loaded && is_slave) begin
            state_r <= pwm_clk_pkg::ST_EXT;
          end else if (i_cfg_loaded && ext_en) begin
            state_r <= pwm_clk_pkg::ST_DETECT;
          end else if (i_cfg_loaded) begin
            state_r <= pwm_clk_pkg::ST_INT;
          end
        end
        pwm_clk_pkg::ST_DETECT: begin
          // One window decides
          if (det_if.done && det_if.in_window) begin
            state_r <= pwm_clk_pkg::ST_EXT;
          end else if (det_if.done) begin
            state_r <= pwm_clk_pkg::ST_INT;
          end
        end
        pwm_clk_pkg::ST_EXT: begin
          // Failure falls back only when enabled
          if (det_if.done && !det_if.in_window && auto_back) begin
            state_r <= pwm_clk_pkg::ST_INT;
          end else if (!ext_en && !is_slave) begin
            state_r <= pwm_clk_pkg::ST_INT;
          end
        end
        pwm_clk_pkg::ST_INT: begin
          state_r <= pwm_clk_pkg::ST_INT;
        end
      endcase
    end
  end

  assign o_clk_state = state_r;

  // ----------------------------------------------------------------
  // PWM timebase
  // ----------------------------------------------------------------
  logic       sel_ext_r;   // Active source
  logic [7:0] period_r;    // Ticks per switching period
  logic [7:0] cnt_r;       // Position in period
  logic       tick;        // Timebase advance
  logic       wrap;        // Last tick of a period

  assign tick = sel_ext_r ? ext_edge : 1'b1;
  assign wrap = tick && (cnt_r >= period_r - 8'h01);

  // Move to external only at a period boundary
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_ext_r <= 1'b0;
    end else if (state_r != pwm_clk_pkg::ST_EXT) begin
      sel_ext_r <= 1'b0;   // Dead source: internal ticks finish the pulse
    end else if (wrap) begin
      sel_ext_r <= 1'b1;
    end
  end

  // Period counter; new period length taken at wrap
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r    <= 8'h00;
      period_r <= 8'(pwm_clk_pkg::PERIOD_MULT * 2);
    end else if (wrap) begin
      cnt_r    <= 8'h00;
      period_r <= 8'(pwm_clk_pkg::PERIOD_MULT * (int'(div_code) + 1));
    end else if (tick) begin
      cnt_r    <= cnt_r + 8'h01;
    end
  end

  assign o_period_ticks = period_r;
  assign o_clk_src_ext  = sel_ext_r;

  // ----------------------------------------------------------------
  // Per-channel duty clamp and output
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < pwm_clk_pkg::NUM_CH; ch++) begin : g_ch
      logic [6:0]  duty_eff;   // Clamped duty in percent
      logic [14:0] on_prod;
      logic [7:0]  on_ticks;

      // Clamp holds except where the one-tick minimum on time exceeds the ceiling
      always_comb begin
        duty_eff = i_duty_request[ch];
        if (duty_eff > i_channel_duty_ceiling[ch]) begin
          duty_eff = i_channel_duty_ceiling[ch];
        end
        if (duty_eff > 7'(pwm_clk_pkg::PCT_FULL)) begin
          duty_eff = 7'(pwm_clk_pkg::PCT_FULL);
        end
        on_prod  = 15'(period_r) * 15'(duty_eff);
        on_ticks = 8'(on_prod / 15'(pwm_clk_pkg::PCT_FULL));
        if (duty_eff != 7'h00 && on_ticks < 8'(pwm_clk_pkg::MIN_ON_CYC)) begin
          on_ticks = 8'(pwm_clk_pkg::MIN_ON_CYC);
        end
      end

      // High for the first on_ticks of each period; off when setting bad
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          o_pwm[ch] <= 1'b0;
        end else if (o_freq_invalid) begin
          o_pwm[ch] <= 1'b0;
        end else if (tick) begin
          o_pwm[ch] <= wrap ? (on_ticks != 8'h00) : (cnt_r + 8'h01 < on_ticks);
        end
      end

      // Ceiling above recommendation voids overcurrent flags
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          o_ocp_flags_invalid[ch] <= 1'b0;
        end else begin
          o_ocp_flags_invalid[ch] <= i_channel_duty_ceiling[ch] > duty_rec;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Master forwarding of clock and sync
  // ----------------------------------------------------------------
  logic master_on;   // Master role, configuration loaded
  logic clk_fwd_r;   // Forwarded clock level
  logic sync_r;      // Period start pulse

  assign master_on = is_master && (state_r != pwm_clk_pkg::ST_BOOT);

  // Forwarded clock toggles on every tick; sync marks period start
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      clk_fwd_r <= 1'b0;
      sync_r    <= 1'b0;
    end else begin
      clk_fwd_r <= master_on && tick ? ~clk_fwd_r : (master_on & clk_fwd_r);
      sync_r    <= master_on && wrap;
    end
  end

  // Drive the chosen pins; enable low while driving
  genvar g;
  generate
    for (g = 0; g < pwm_clk_pkg::NUM_GPIO; g++) begin : g_pin
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          o_gpio_out[g]  <= 1'b0;
          o_gpio_oe_n[g] <= 1'b1;
        end else if (master_on && i_clk_out_sel == 3'(g)) begin
          o_gpio_out[g]  <= clk_fwd_r;
          o_gpio_oe_n[g] <= 1'b0;
        end else if (master_on && i_sync_out_sel == 3'(g)) begin
          o_gpio_out[g]  <= sync_r;
          o_gpio_oe_n[g] <= 1'b0;
        end else begin
          o_gpio_out[g]  <= 1'b0;
          o_gpio_oe_n[g] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule

/* File: sim/ext_clk_src.sv */
/* External clock source feeding one general purpose pin.
   Runs free of the system clock; rests low while stopped. */
module ext_clk_src (
  input  wire logic        i_run,      // Clock runs while high
  input  wire logic [15:0] i_half_ns,  // Half period in ns
  output logic             o_clk       // Clock toward the pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Odd start offset: phase unrelated to i_mclk
  initial begin
    o_clk = 1'b0;
    #13;
    forever begin
      if (i_run) begin
        #(i_half_ns) o_clk = 1'b1;
        #(i_half_ns) o_clk = 1'b0;
      end else begin
        #7 o_clk = 1'b0;  // Failed clock stands low
      end
    end
  end
endmodule

/* File: sim/pwm_clock_freq_sync_asserts.sv */
/* Concurrent checks on the PWM clock block.
   Sees only the top module ports; bound from the bench top file. */
module pwm_clock_freq_sync_asserts #(
  parameter int REF_WINDOW = 1024  // Detector window in system clocks
) (
  input wire logic                                i_mclk,
  input wire logic                                i_rst,
  input wire logic [7:0]                          i_switching_frequency_select,
  input wire logic [3:0]                          i_sync_mode,
  input wire logic                                i_cfg_loaded,
  input wire logic [pwm_clk_pkg::NUM_CH-1:0][6:0] i_channel_duty_ceiling,
  input wire logic [pwm_clk_pkg::NUM_GPIO-1:0]    o_gpio_oe_n,
  input wire logic [pwm_clk_pkg::NUM_CH-1:0]      o_pwm,
  input wire logic [pwm_clk_pkg::NUM_CH-1:0]      o_ocp_flags_invalid,
  input wire logic [15:0]                         o_osc_khz,
  input wire logic [6:0]                          o_duty_rec_pct,
  input wire logic                                o_freq_invalid,
  input wire logic                                o_clk_src_ext,
  input wire logic [1:0]                          o_clk_state
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Helpers
  // ----------------
  int det_cyc;  // Cycles spent in detection
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) det_cyc <= 0;
    else det_cyc <= (o_clk_state == 2'h1) ? det_cyc + 1 : 0;
  end
  wire logic [2:0] osc = i_switching_frequency_select[6:4];  // Oscillator code
  wire logic [2:0] dv  = i_switching_frequency_select[2:0];  // Divider code
  wire logic       bad = (dv == 3'h0) || (dv == 3'h5 && osc == 3'h7) ||
                         (dv == 3'h6 && osc > 3'h4) || (dv == 3'h7 && osc > 3'h3);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Configuration loaded while still booting
  sequence boot_done;
    o_clk_state == 2'h0 && i_cfg_loaded;
  endsequence
  // ----------------
  // Assertions
  // ----------------
  a_osc_decode: assert property (
    $past(!i_rst) |-> o_osc_khz == 16'(48000 - 3200 * $past(osc)))
    else $error("oscillator frequency wrong");
  a_combo_flag: assert property (
    $past(!i_rst) |-> o_freq_invalid == $past(bad))
    else $error("invalid combination flag wrong");
  a_duty_rec: assert property (
    $past(!i_rst) |-> o_duty_rec_pct == pwm_clk_pkg::DUTY_REC_PCT[$past(dv)])
    else $error("recommended ceiling wrong");
  a_ceiling_flag: assert property (
    $past(!i_rst) |-> o_ocp_flags_invalid[0] ==
    ($past(i_channel_duty_ceiling[0]) > pwm_clk_pkg::DUTY_REC_PCT[$past(dv)]))
    else $error("overcurrent flag validity wrong");
  a_pwm_quiet: assert property (
    o_freq_invalid [*3] |-> o_pwm == '0)
    else $error("pulses on invalid setting");
  a_boot_hold: assert property (
    o_clk_state == 2'h0 && !i_cfg_loaded |=> o_clk_state == 2'h0 && !o_clk_src_ext)
    else $error("left boot before loading");
  a_slave_take: assert property (
    boot_done ##0 i_sync_mode[2] |=> o_clk_state == 2'h2)
    else $error("slave did not take master clock");
  a_detect_entry: assert property (
    boot_done ##0 (!i_sync_mode[2] && i_sync_mode[0]) |=> o_clk_state == 2'h1)
    else $error("detection not started");
  a_detect_bound: assert property (
    det_cyc <= REF_WINDOW)
    else $error("detection took too long");
  a_int_final: assert property (
    o_clk_state == 2'h3 |=> o_clk_state == 2'h3 && !o_clk_src_ext)
    else $error("internal state not final");
  a_ext_source: assert property (
    $rose(o_clk_src_ext) |-> $past(o_clk_state) == 2'h2)
    else $error("external ticks outside EXT");
  a_pins_idle: assert property (
    o_clk_state == 2'h0 && $past(o_clk_state) == 2'h0 |-> &o_gpio_oe_n)
    else $error("pins driven before loading");
endmodule

/* File: sim/pwm_clock_freq_sync_tb.sv */
/* Bench for the PWM clock block; integer model checked at each result.
   Needs package, design, checker and clock source compiled first. */
module pwm_clock_freq_sync_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Signals
  // ----------------
  localparam int RW = 16;  // Short window
  logic        i_mclk = 1'b0;  // 20 MHz clock
  logic        i_rst = 1'b1;  // Reset
  logic [7:0]  i_switching_frequency_select = 8'h01;  // Select
  logic [3:0]  i_sync_mode = 4'h0;  // Mode bits
  logic [6:0]  i_window_pct = 7'h19;  // 25 percent
  logic [15:0] i_ext_expected = 16'h0004;  // Edges per window
  logic        i_cfg_loaded = 1'b0;  // Config loaded
  logic [2:0]  i_clk_in_sel = 3'h0, i_clk_out_sel = 3'h1, i_sync_out_sel = 3'h2;
  logic [3:0][6:0] i_duty_request = '0, i_channel_duty_ceiling = '0;
  logic [5:0]  gpio_rnd = 6'h00;  // Spare pin noise
  logic        ext_run = 1'b0, ext_clk;  // Partner clock
  logic [15:0] ext_half = 16'h0065;  // 101 ns half
  wire logic [5:0] i_gpio_in = {gpio_rnd[5:1], ext_clk};
  logic [5:0]  o_gpio_out, o_gpio_oe_n;
  logic [3:0]  o_pwm, o_ocp_flags_invalid;
  logic [15:0] o_osc_khz;
  logic [7:0]  o_period_ticks;
  logic [6:0]  o_duty_rec_pct;
  logic        o_freq_invalid, o_clk_src_ext, last;
  logic [1:0]  o_clk_state;
  logic [7:0]  sels[4] = '{8'h01, 8'h74, 8'h07, 8'h75}; // PWM cases
  int          rec_tab[8] = '{0, 78, 86, 84, 89, 88, 88, 86};
  int          bad_count = 0, compares = 0, cycles = 0, p, hi[4], t, s;
  bit          bad;
  pwm_clock_freq_sync #(.REF_WINDOW(RW)) i_dut (.*);
  ext_clk_src i_ext (.i_run(ext_run), .i_half_ns(ext_half), .o_clk(ext_clk));
  // ----------------
  // Clock, timeout, model and tasks
  // ----------------
  initial forever #25 i_mclk = ~i_mclk;
  // Hang guard
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  function automatic bit bad_combo(int o, int d);
    return d == 0 || (d == 5 && o == 7) || (d == 6 && o >= 5) || (d == 7 && o >= 4);
  endfunction
  // Expected on ticks for a period
  function automatic int on_ticks(int p, int r, int c);
    int d = (r < c) ? r : c;
    d = (d > 100) ? 100 : d;
    on_ticks = p * d / 100;
    if (d > 0 && on_ticks < 1) on_ticks = 1;
  endfunction
  task automatic chk(input string what, input int exp, input logic [15:0] got);
    compares++;
    if (got !== 16'(exp)) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic rnd_duty();
    for (int k = 0; k < 4; k++) begin
      i_duty_request[k] = 7'($urandom_range(110));
      i_channel_duty_ceiling[k] = 7'($urandom_range(100));
    end
  endtask
  // Reset, check boot, then load configuration
  task automatic start(input logic [3:0] mode);
    @(negedge i_mclk);
    i_rst = 1'b1;
    i_cfg_loaded = 1'b0;
    i_sync_mode = mode;
    i_switching_frequency_select = 8'h01;
    gpio_rnd = 6'($urandom);
    repeat (2) @(negedge i_mclk);
    chk("reset period", 32, o_period_ticks);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk("boot state", 0, o_clk_state);
    chk("boot pins", 6'h3F, o_gpio_oe_n);
    i_cfg_loaded = 1'b1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    void'($urandom(32'h73B4));
    start(4'h0);
    for (int c = 0; c < 64; c++) begin
      @(negedge i_mclk);
      i_switching_frequency_select = {1'($urandom), c[5:3], 1'($urandom), c[2:0]};
      rnd_duty();
      @(negedge i_mclk);
      chk("osc", 48000 - 3200 * (c / 8), o_osc_khz);
      chk("invalid", bad_combo(c / 8, c % 8), o_freq_invalid);
      chk("rec", rec_tab[c % 8], o_duty_rec_pct);
      for (int k = 0; k < 4; k++)
        chk("ocp", i_channel_duty_ceiling[k] > rec_tab[c % 8], o_ocp_flags_invalid[k]);
    end
    $display("test decode done");
    for (int j = 0; j < 4; j++) begin
      @(negedge i_mclk);
      i_switching_frequency_select = sels[j];
      rnd_duty();
      repeat (300) @(negedge i_mclk);
      p = 16 * (sels[j][2:0] + 1);
      bad = bad_combo(sels[j][6:4], sels[j][2:0]);
      if (!bad) chk("period", p, o_period_ticks);
      hi = '{0, 0, 0, 0};
      repeat (4 * p) begin
        @(negedge i_mclk);
        for (int k = 0; k < 4; k++) hi[k] += (o_pwm[k] === 1'b1);
      end
      for (int k = 0; k < 4; k++)
        chk("pwm", bad ? 0 : 4 * on_ticks(p, i_duty_request[k], i_channel_duty_ceiling[k]),
            16'(hi[k]));
    end
    $display("test pwm done");
    ext_run = 1'b1;
    start(4'h9);
    repeat (100) @(negedge i_mclk);
    chk("state", 2, o_clk_state);
    chk("source", 1, o_clk_src_ext);
    ext_run = 1'b0;
    repeat (60) @(negedge i_mclk);
    chk("state", 3, o_clk_state);
    chk("source", 0, o_clk_src_ext);
    ext_half = 16'h012F;
    ext_run = 1'b1;
    start(4'h1);
    repeat (100) @(negedge i_mclk);
    chk("state", 3, o_clk_state);
    chk("source", 0, o_clk_src_ext);
    ext_run = 1'b0;
    $display("test external done");
    start(4'h4);
    @(negedge i_mclk);
    chk("state", 2, o_clk_state);
    start(4'h2);
    repeat (10) @(negedge i_mclk);
    chk("pins", 6'h39, o_gpio_oe_n);
    last = o_gpio_out[1];
    t = 0;
    s = 0;
    repeat (64) begin
      @(negedge i_mclk);
      t += (o_gpio_out[1] !== last);
      last = o_gpio_out[1];
      s += (o_gpio_out[2] === 1'b1);
    end
    chk("clock toggles", 64, 16'(t));
    chk("sync pulses", 2, 16'(s));
    $display("test roles done");
    summarize();
  end
endmodule
bind pwm_clock_freq_sync pwm_clock_freq_sync_asserts #(.REF_WINDOW(REF_WINDOW)) i_chk (.*);
